/* src/ddrio_top.sv */
// ddrio_top: double-rate gearing cells behind an ahb-lite register slave
// assumes every link clock and pin is asynchronous to ref_clk and much slower
`timescale 1ns/100ps
`default_nettype none
module ddrio_top
  import ddrio_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // link clocks
  input  wire logic        fastEdgeClock,
  input  wire logic        sysClkPin,
  input  wire logic        readStrobeShifted,
  input  wire logic        writeClockShifted,
  // generic gearing pins
  input  wire logic        rxGearPin,
  output logic             txGearPin,
  output logic             txX1Pin,
  // memory pins
  input  wire logic        memRxPin,
  output logic             memDataOut,
  output logic             memDataOe,
  output logic             memStrobeOut,
  output logic             memStrobeOe
);

  // synchroniser bit positions
  localparam int S_EDGE = 0;
  localparam int S_SYS  = 1;
  localparam int S_RSTB = 2;
  localparam int S_WCLK = 3;
  localparam int S_GRX  = 4;
  localparam int S_MRX  = 5;
  localparam int S_SPR  = 6;

  logic [SYNC_W-1:0] sync1_ff;
  logic [SYNC_W-1:0] sync2_ff;
  logic [SYNC_W-1:0] prev_ff;
  logic [SYNC_W-1:0] rise;
  logic [SYNC_W-1:0] fall;
  logic              edgeStb;
  logic              sysRise;
  logic              sysFall;

  ddrio_ctrl_s       ctrl_ff;
  ddrio_txw_s        txw_ff;
  ddrio_rxw_s        rxw;
  logic [7:0]        gearRxWord;
  logic              wrPend_ff;
  logic [7:0]        wrAddr_ff;
  logic [31:0]       hrdata_ff;
  logic              addrPhase;
  logic [7:0]        rdAddr;
  logic [31:0]       rdMux;

  logic              memCapRise_ff;
  logic              memCapFall_ff;
  logic [1:0]        memStage2_ff;
  logic [1:0]        memStage3_ff;
  logic              capPol_ff;
  logic              polSeen_ff;
  logic              stage2Take;

  logic [1:0]        memTxHold_ff;
  logic              memDataOut_ff;
  logic              memDataOe_ff;
  logic              memStrobeOut_ff;
  logic              memStrobeOe_ff;
  logic              stbOeTake;
  logic [1:0]        x1Hold_ff;
  logic              txX1_ff;

  // two-flop synchronisers; the third rank only serves edge detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      prev_ff  <= '0;
    end else begin
      sync1_ff <= {1'b0, memRxPin, rxGearPin, writeClockShifted, readStrobeShifted,
                   sysClkPin, fastEdgeClock};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // edge pulses of the sampled link clocks
  assign rise    = sync2_ff & ~prev_ff;
  assign fall    = ~sync2_ff & prev_ff;
  assign edgeStb = rise[S_EDGE] | fall[S_EDGE];
  assign sysRise = rise[S_SYS];
  assign sysFall = fall[S_SYS];

  // ahb-lite decode; zero wait state, always okay
  assign addrPhase = hsel && htrans[1] && hready;
  assign rdAddr    = haddr[ADDR_MSB:ADDR_LSB];
  assign rxw       = {capPol_ff, memStage3_ff, gearRxWord};
  assign rdMux     = (rdAddr == ADDR_CTRL)   ? 32'(ctrl_ff) :
                     (rdAddr == ADDR_TXDATA) ? 32'(txw_ff)  :
                     (rdAddr == ADDR_RXDATA) ? 32'(rxw)     : 32'h0000_0000;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  // address phase capture and read data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      wrPend_ff <= addrPhase && hwrite;
      if (addrPhase) begin
        wrAddr_ff <= rdAddr;
      end
      if (addrPhase && !hwrite) begin
        hrdata_ff <= rdMux;
      end
    end
  end

  // register writes in the data phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_RST;
      txw_ff  <= TXW_RST;
    end else if (wrPend_ff) begin
      if (wrAddr_ff == ADDR_CTRL) begin
        ctrl_ff <= ddrio_ctrl_s'(hwdata[$bits(ddrio_ctrl_s)-1:0]);
      end
      if (wrAddr_ff == ADDR_TXDATA) begin
        txw_ff <= ddrio_txw_s'(hwdata[$bits(ddrio_txw_s)-1:0]);
      end
    end
  end

  // generic receive path
  ddrio_rx_gear u_rx_gear (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .bitStb   (edgeStb),
    .sysRise  (sysRise),
    .mode     (ctrl_ff.mode),
    .alignOdd (ctrl_ff.alignOdd),
    .serIn    (sync2_ff[S_GRX]),
    .parOut   (gearRxWord)
  );

  // generic transmit path
  ddrio_tx_gear u_tx_gear (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .bitStb  (edgeStb),
    .sysRise (sysRise),
    .mode    (ctrl_ff.mode),
    .parIn   (txw_ff.gearWord),
    .serOut  (txGearPin)
  );

  // memory receive stage one on both read strobe edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      memCapRise_ff <= 1'b0;
      memCapFall_ff <= 1'b0;
    end else begin
      if (rise[S_RSTB]) begin
        memCapRise_ff <= sync2_ff[S_MRX];
      end
      if (fall[S_RSTB]) begin
        memCapFall_ff <= sync2_ff[S_MRX];
      end
    end
  end

  // capture polarity taken from system clock level at the first strobe edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capPol_ff  <= 1'b0;
      polSeen_ff <= 1'b0;
    end else if (!polSeen_ff && (rise[S_RSTB] || fall[S_RSTB])) begin
      capPol_ff  <= sync2_ff[S_SYS];
      polSeen_ff <= 1'b1;
    end
  end

  // stages two and three of the memory receive cell
  assign stage2Take = capPol_ff ? sysRise : sysFall;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      memStage2_ff <= 2'h0;
      memStage3_ff <= 2'h0;
    end else begin
      if (stage2Take) begin
        memStage2_ff <= {memCapFall_ff, memCapRise_ff};
      end
      if (sysRise) begin
        memStage3_ff <= memStage2_ff;
      end
    end
  end

  // memory data output: load on system clock, serialise on shifted write clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      memTxHold_ff  <= 2'h0;
      memDataOut_ff <= 1'b0;
      memDataOe_ff  <= 1'b0;
    end else begin
      if (sysRise) begin
        memTxHold_ff <= txw_ff.memPair;
      end
      if (rise[S_WCLK]) begin
        memDataOut_ff <= memTxHold_ff[0];
        memDataOe_ff  <= ctrl_ff.memTxEn;
      end else if (fall[S_WCLK]) begin
        memDataOut_ff <= memTxHold_ff[1];
      end
    end
  end

  // memory strobe output on the unshifted system clock, optional inverted oe clock
  assign stbOeTake = ctrl_ff.stbInvert ? sysFall : sysRise;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      memStrobeOut_ff <= 1'b0;
      memStrobeOe_ff  <= 1'b0;
    end else begin
      if (sysRise) begin
        memStrobeOut_ff <= STB_PATTERN[0];
      end else if (sysFall) begin
        memStrobeOut_ff <= STB_PATTERN[1];
      end
      if (stbOeTake) begin
        memStrobeOe_ff <= ctrl_ff.memTxEn;
      end
    end
  end

  // x1 transmit: bit 0 in the high phase, bit 1 in the low phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      x1Hold_ff <= 2'h0;
      txX1_ff   <= 1'b0;
    end else if (sysRise) begin
      x1Hold_ff <= txw_ff.x1Pair;
      txX1_ff   <= txw_ff.x1Pair[0];
    end else if (sysFall) begin
      txX1_ff   <= x1Hold_ff[1];
    end
  end

  assign memDataOut   = memDataOut_ff;
  assign memDataOe    = memDataOe_ff;
  assign memStrobeOut = memStrobeOut_ff;
  assign memStrobeOe  = memStrobeOe_ff;
  assign txX1Pin      = txX1_ff;

endmodule // ddrio_top
`default_nettype wire

/* src/ddrio_pkg.sv */
// ddrio_pkg: shared constants, types and helpers of the double-rate gearing block
// assumes a single 10 MHz reference clock samples every link-side clock and pin
package ddrio_pkg;

  // register byte addresses on the ahb-lite bus
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TXDATA = 8'h04;
  localparam logic [7:0] ADDR_RXDATA = 8'h08;
  localparam int         ADDR_LSB    = 0;
  localparam int         ADDR_MSB    = 7;

  // gearing modes, one-hot
  typedef enum logic [2:0] {
    MODE_X2    = 3'h1,
    MODE_X4    = 3'h2,
    MODE_SEVEN = 3'h4
  } ddrio_mode_e;

  // control register layout
  typedef struct packed {
    logic        stbInvert;
    logic        memTxEn;
    logic        alignOdd;
    ddrio_mode_e mode;
  } ddrio_ctrl_s;

  // transmit data register layout
  typedef struct packed {
    logic [1:0] x1Pair;
    logic [1:0] memPair;
    logic [7:0] gearWord;
  } ddrio_txw_s;

  // receive status register layout
  typedef struct packed {
    logic       capPol;
    logic [1:0] memPair;
    logic [7:0] gearWord;
  } ddrio_rxw_s;

  localparam ddrio_ctrl_s CTRL_RST    = 6'h01;
  localparam ddrio_txw_s  TXW_RST     = 12'h000;
  localparam logic [1:0]  STB_PATTERN = 2'h1;
  localparam logic [3:0]  LEN_X2      = 4'h4;
  localparam logic [3:0]  LEN_X4      = 4'h8;
  localparam logic [3:0]  LEN_SEVEN   = 4'h7;
  localparam int          SYNC_W      = 7;

  // bits per parallel word for a gearing mode
  function automatic logic [3:0] wordLen(input ddrio_mode_e mode);
    logic [3:0] len;
    len = LEN_X2;
    if (mode == MODE_X4) begin
      len = LEN_X4;
    end else if (mode == MODE_SEVEN) begin
      len = LEN_SEVEN;
    end
    return len;
  endfunction

  // last bit index of a word
  function automatic logic [2:0] lastIdx(input ddrio_mode_e mode);
    logic [3:0] len;
    len = wordLen(mode) - 4'h1;
    return len[2:0];
  endfunction

endpackage

/* src/ddrio_rx_gear.sv */
// ddrio_rx_gear: one-pin deserialiser for the 1:4, 1:8 and 1:7 gearings
// assumes bitStb pulses once per edge-clock edge and sysRise once per system clock rise
`timescale 1ns/100ps
`default_nettype none
module ddrio_rx_gear
  import ddrio_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // timing strobes
  input  wire logic        bitStb,
  input  wire logic        sysRise,
  // configuration
  input  wire ddrio_mode_e mode,
  input  wire logic        alignOdd,
  // data
  input  wire logic        serIn,
  output logic [7:0]       parOut
);

  logic       capBit_ff;
  logic       capVal_ff;
  logic [7:0] asm_ff;
  logic [7:0] hold_ff;
  logic [7:0] parOut_ff;
  logic [2:0] bitCnt_ff;
  logic       alignPrev_ff;
  logic       slip_ff;
  logic [7:0] asmNext;
  logic       wordDone;
  logic       slipNow;

  // placement of the new bit, earliest bit lands at index 0
  assign asmNext  = asm_ff | (8'(capBit_ff) << bitCnt_ff);
  assign wordDone = capVal_ff && !slip_ff && (bitCnt_ff == lastIdx(mode));
  assign slipNow  = capVal_ff && slip_ff;
  assign parOut   = parOut_ff;

  // stage one: capture on every edge of the edge clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      capBit_ff <= 1'b0;
      capVal_ff <= 1'b0;
    end else begin
      capVal_ff <= bitStb;
      if (bitStb) begin
        capBit_ff <= serIn;
      end
    end
  end

  // odd alignment drops one bit so the word boundary moves by one slot
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alignPrev_ff <= 1'b0;
      slip_ff      <= 1'b0;
    end else begin
      alignPrev_ff <= alignOdd;
      if (alignOdd && !alignPrev_ff) begin
        slip_ff <= 1'b1;
      end else if (slipNow) begin
        slip_ff <= 1'b0;
      end
    end
  end

  // word assembly; one bit per step, seven mode closes a word after seven steps
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      asm_ff    <= 8'h00;
      bitCnt_ff <= 3'h0;
      hold_ff   <= 8'h00;
    end else if (wordDone) begin
      hold_ff   <= asmNext;
      asm_ff    <= 8'h00;
      bitCnt_ff <= 3'h0;
    end else if (capVal_ff && !slip_ff) begin
      asm_ff    <= asmNext;
      bitCnt_ff <= bitCnt_ff + 3'h1;
    end
  end

  // stage three: hand the word to the system clock domain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      parOut_ff <= 8'h00;
    end else if (sysRise) begin
      parOut_ff <= hold_ff;
    end
  end

endmodule // ddrio_rx_gear
`default_nettype wire

/* src/ddrio_tx_gear.sv */
// ddrio_tx_gear: one-pin serialiser for the 4:1, 8:1 and 7:1 gearings
// assumes bitStb pulses once per edge-clock edge and sysRise once per system clock rise
`timescale 1ns/100ps
`default_nettype none
module ddrio_tx_gear
  import ddrio_pkg::*;
(
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // timing strobes
  input  wire logic        bitStb,
  input  wire logic        sysRise,
  // configuration
  input  wire ddrio_mode_e mode,
  // data
  input  wire logic [7:0]  parIn,
  output logic             serOut
);

  logic [7:0] in_ff;
  logic [7:0] hold_ff;
  logic [2:0] bitCnt_ff;
  logic       serOut_ff;
  logic       update;

  assign update = bitStb && (bitCnt_ff == lastIdx(mode));
  assign serOut = serOut_ff;

  // stage one: parallel word registered on the system clock
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_ff <= 8'h00;
    end else if (sysRise) begin
      in_ff <= parIn;
    end
  end

  // stages two and three: hold at update, send bit 0 first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ff   <= 8'h00;
      bitCnt_ff <= 3'h0;
      serOut_ff <= 1'b0;
    end else if (bitStb) begin
      serOut_ff <= hold_ff[bitCnt_ff];
      if (update) begin
        hold_ff   <= in_ff;
        bitCnt_ff <= 3'h0;
      end else begin
        bitCnt_ff <= bitCnt_ff + 3'h1;
      end
    end
  end

endmodule // ddrio_tx_gear
`default_nettype wire

/* sim/ddrio_checker.sv */
// ddrio_checker: port assertions on ddrio_top
// assumes a bind onto ddrio_top; link clocks are sampled by ref_clk
`timescale 1ns/100ps
`default_nettype none
module ddrio_checker
  import ddrio_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // pins
  input wire logic        sysClkPin,
  input wire logic        writeClockShifted,
  input wire logic        txX1Pin,
  input wire logic        memDataOut,
  input wire logic        memDataOe,
  input wire logic        memStrobeOut,
  input wire logic        memStrobeOe
);
  logic        wPend_ff;
  logic [7:0]  wAddr_ff;
  ddrio_ctrl_s ctl_ff;
  ddrio_txw_s  txw_ff;
  // write decode for the register shadow
  wire logic   wTake  = hsel && htrans[1] && hready && hwrite;
  wire logic   ctlHit = wPend_ff && (wAddr_ff == ADDR_CTRL);
  wire logic   txwHit = wPend_ff && (wAddr_ff == ADDR_TXDATA);

  // shadow of the writable registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wPend_ff <= 1'b0;
      wAddr_ff <= 8'h00;
      ctl_ff   <= CTRL_RST;
      txw_ff   <= TXW_RST;
    end else begin
      wPend_ff <= wTake;
      wAddr_ff <= haddr[7:0];
      ctl_ff   <= ctlHit ? ddrio_ctrl_s'(hwdata[5:0]) : ctl_ff;
      txw_ff   <= txwHit ? ddrio_txw_s'(hwdata[11:0]) : txw_ff;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // system clock edges seen at ref_clk
  sequence s_sysRise;
    $rose(sysClkPin);
  endsequence
  sequence s_sysFall;
    $fell(sysClkPin);
  endsequence

  property p_okay;
    hreadyout && !hresp;
  endproperty
  property p_stbHigh;
    memStrobeOe && ctl_ff.memTxEn ##0 s_sysRise |-> ##[1:5] memStrobeOut;
  endproperty
  property p_stbLow;
    memStrobeOe && ctl_ff.memTxEn ##0 s_sysFall |-> ##[1:5] !memStrobeOut;
  endproperty
  property p_x1First;
    s_sysRise |-> ##[1:5] (txX1Pin == txw_ff.x1Pair[0]);
  endproperty
  property p_x1Second;
    s_sysFall |-> ##[1:5] (txX1Pin == txw_ff.x1Pair[1]);
  endproperty
  property p_memFirst;
    memDataOe && ctl_ff.memTxEn && $rose(writeClockShifted)
      |-> ##[1:5] (memDataOut == txw_ff.memPair[0]);
  endproperty
  property p_memSecond;
    memDataOe && ctl_ff.memTxEn && $fell(writeClockShifted)
      |-> ##[1:5] (memDataOut == txw_ff.memPair[1]);
  endproperty
  property p_stbOeHold;
    ctl_ff.memTxEn && ctl_ff.stbInvert && !memStrobeOe ##0 s_sysRise
      |-> ##1 (!memStrobeOe) [*5];
  endproperty
  property p_stbOe;
    ctl_ff.memTxEn && (ctl_ff.stbInvert ? $fell(sysClkPin) : $rose(sysClkPin))
      |-> ##[1:5] memStrobeOe;
  endproperty

  a_okay: assert property (p_okay) else $error("bus answer not okay");
  a_stbHigh: assert property (p_stbHigh) else $error("strobe not high");
  a_stbLow: assert property (p_stbLow) else $error("strobe not low");
  a_x1First: assert property (p_x1First) else $error("x1 first bit");
  a_x1Second: assert property (p_x1Second) else $error("x1 second bit");
  a_memFirst: assert property (p_memFirst) else $error("mem first bit");
  a_memSecond: assert property (p_memSecond) else $error("mem second bit");
  a_stbOe: assert property (p_stbOe) else $error("strobe enable edge");
  a_stbOeHold: assert property (p_stbOeHold) else $error("strobe enable too early");
endmodule // ddrio_checker

bind ddrio_top ddrio_checker chk_u (
  .ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .sysClkPin, .writeClockShifted, .txX1Pin,
  .memDataOut, .memDataOe, .memStrobeOut, .memStrobeOe
);
`default_nettype wire

/* sim/ddrio_link_model.sv */
// ddrio_link_model: far-side clocks, source and sink of the gearing pins
// assumes 1 ns units; one 400 ns bit slot per edge-clock edge
`timescale 1ns/100ps
`default_nettype none
module ddrio_link_model (
  // control
  input  wire logic        run,
  input  wire logic [3:0]  len,
  input  wire logic [7:0]  rxWord,
  // clocks
  output var  logic        fastEdgeClock,
  output var  logic        sysClkPin,
  output var  logic        readStrobeShifted,
  output var  logic        writeClockShifted,
  // pins
  output var  logic        rxGearPin,
  output var  logic        memRxPin,
  input  wire logic        txGearPin,
  output var  logic [31:0] txStream
);
  int   slot = 0;
  logic act;

  // idle levels
  initial begin
    {fastEdgeClock, sysClkPin, readStrobeShifted, writeClockShifted, rxGearPin, memRxPin} = 6'h00;
    txStream = 32'h0000_0000;
  end
  // bit slots; a frame always ends on a word boundary with clocks still
  always begin
    #200;
    act = run || (slot != 0);
    if (act) begin
      fastEdgeClock = ~fastEdgeClock;
      sysClkPin     = (slot < (len + 1) / 2);
    end
    #200;
    rxGearPin = act ? rxWord[slot] : ~rxGearPin;
    slot      = act ? (slot + 1) % len : slot;
  end
  // quarter-period shifted strobes; read data follows the system level
  always @(sysClkPin) readStrobeShifted <= #(len * 100) sysClkPin;
  always @(sysClkPin) writeClockShifted <= #(len * 100) sysClkPin;
  always @(sysClkPin) memRxPin = sysClkPin;
  // serial sink, oldest bit lowest
  always @(fastEdgeClock) txStream = {txGearPin, txStream[31:1]};
endmodule // ddrio_link_model
`default_nettype wire

/* sim/ddrio_top_test.sv */
// ddrio_top_test: register-level tests of the gearing cells over ahb-lite
// assumes ddrio_link_model makes all link clocks and pin data
`timescale 1ns/100ps
`default_nettype none
module ddrio_top_test
  import ddrio_pkg::*;
;
  localparam logic [7:0] WORD = 8'h0B;
  logic        ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, run;
  logic        fastEdgeClock, sysClkPin, readStrobeShifted, writeClockShifted;
  logic        rxGearPin, txGearPin, txX1Pin, memRxPin;
  logic        memDataOut, memDataOe, memStrobeOut, memStrobeOe;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  len;
  logic [31:0] haddr, hwdata, hrdata, v, txStream;
  int          fails = 0;
  int          nTests = 0;
  int          cycles = 0;
  ddrio_mode_e modes [3] = '{MODE_X2, MODE_X4, MODE_SEVEN};
  int          lens [3] = '{4, 8, 7};

  ddrio_top dut_u (
    .ref_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .fastEdgeClock,
    .sysClkPin, .readStrobeShifted, .writeClockShifted, .rxGearPin,
    .txGearPin, .txX1Pin, .memRxPin, .memDataOut, .memDataOe,
    .memStrobeOut, .memStrobeOe
  );
  ddrio_link_model model_u (
    .run, .len, .rxWord(WORD), .fastEdgeClock, .sysClkPin,
    .readStrobeShifted, .writeClockShifted, .rxGearPin, .memRxPin,
    .txGearPin, .txStream
  );

  // clock and hang guard
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finalReport();
    end
  end

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one single ahb-lite transfer
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h00_0000, a};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0000_0000, d);
  endtask
  // let the link run, then wait for the frame to close
  task automatic runFor(input int n);
    run <= 1'b1;
    repeat (n) @(posedge ref_clk);
    run <= 1'b0;
    repeat (45) @(posedge ref_clk);
  endtask
  // does s hold w's low n bits, bit 0 oldest, at some offset
  function automatic logic hasWord(input logic [31:0] s, input logic [7:0] w, input int n);
    logic [31:0] m;
    logic        hit;
    m   = (32'h0000_0001 << n) - 32'h0000_0001;
    hit = 1'b0;
    for (int k = 0; k <= 32 - n; k++) begin
      hit = hit | (((s >> k) & m) === ({24'h00_0000, w} & m));
    end
    return hit;
  endfunction
  function automatic logic [31:0] rep(input logic [7:0] w, input int n);
    logic [31:0] s;
    for (int k = 0; k < 32; k++) begin
      s[k] = w[k % n];
    end
    return s;
  endfunction
  task automatic finalReport();
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n   = 1'b0;
    {hsel, hwrite, run} = 3'h0;
    htrans  = 2'h0;
    hsize   = 3'h2;
    haddr   = 32'h0000_0000;
    hwdata  = 32'h0000_0000;
    len     = 4'h4;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, v);
    check("ctrl reset", v, 32'(CTRL_RST));
    rd(ADDR_TXDATA, v);
    check("txdata reset", v, 32'(TXW_RST));
    rd(8'h0C, v);
    check("unmapped", v, 32'h0000_0000);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      len <= lens[i][3:0];
      wr(ADDR_CTRL, {26'h000_0000, 3'b010, modes[i]});
      wr(ADDR_TXDATA, {20'h0_0000, 2'b01, 2'b10, WORD});
      runFor(220);
      check("tx order", 32'(hasWord(txStream, WORD, lens[i])), 32'h1);
      rd(ADDR_RXDATA, v);
      check("rx order", 32'(hasWord(rep(WORD, lens[i]), v[7:0], lens[i])), 32'h1);
      check("mem rx", v & 32'h0000_0700, 32'h0000_0500);
      $display("test gearing %0d done", lens[i]);
    end
    check("mem oe", {30'h0000_0000, memDataOe, memStrobeOe}, 32'h3);
    len <= 4'h4;
    wr(ADDR_CTRL, 32'h0000_0001);
    wr(ADDR_RXDATA, 32'hFFFF_FFFF);
    runFor(100);
    check("oe off", {30'h0000_0000, memDataOe, memStrobeOe}, 32'h0);
    rd(ADDR_RXDATA, v);
    check("rx read only", v & 32'h0000_0700, 32'h0000_0500);
    check("rx even align", v & 32'h0000_00FF, 32'h0000_0007);
    // strobe enable must come on only at a falling system edge once inverted
    wr(ADDR_CTRL, 32'h0000_0031);
    runFor(100);
    check("strobe oe inverted", {31'h0000_0000, memStrobeOe}, 32'h1);
    $display("test memory done");
    // a rising odd alignment slips the word boundary by one bit
    wr(ADDR_CTRL, 32'h0000_0009);
    runFor(60);
    rd(ADDR_RXDATA, v);
    check("rx odd align", v & 32'h0000_00FF, 32'h0000_000B);
    $display("test alignment done");
    finalReport();
  end
endmodule // ddrio_top_test
`default_nettype wire
